// [core/pmwc_pkg.sv]
package pmwc_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PMWC_CTRL_OFS = 8'h00;
   localparam logic [7:0] PMWC_WAKE_EN_OFS = 8'h04;
   localparam logic [7:0] PMWC_PIN_WAKE_EN_OFS = 8'h08;
   localparam logic [7:0] PMWC_RST_EN_OFS = 8'h0c;
   localparam logic [7:0] PMWC_RAM_RET_OFS = 8'h10;
   localparam logic [7:0] PMWC_CLK_GATE_OFS = 8'h14;
   localparam logic [7:0] PMWC_STATUS_OFS = 8'h18;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int PMWC_CTRL_SLEEP_TARGET = 0;
   localparam int PMWC_CTRL_FAST_WAKE = 1;
   localparam int PMWC_CTRL_FAST_SRC = 2;
   localparam int PMWC_CTRL_REG_EN = 4;
   localparam int PMWC_CTRL_REG_SRC = 8;
   localparam int PMWC_CTRL_DRV_SRC = 12;
   localparam int PMWC_CTRL_ANALOG_EN = 13;
   localparam logic [31:0] PMWC_CTRL_RST = 32'h0000_2070;
   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int PMWC_NUM_PIN_WAKE = 14;
   localparam int PMWC_NUM_WAKE = 8;
   localparam int PMWC_NUM_RST = 7;
   localparam int PMWC_NUM_RAM = 8;
   localparam int PMWC_NUM_PERIPH = 16;
   localparam logic [7:0] PMWC_WAKE_EN_RST = 8'h00;
   localparam logic [13:0] PMWC_PIN_WAKE_EN_RST = 14'h0000;
   localparam logic [6:0] PMWC_RST_EN_RST = 7'h01;
   localparam logic [7:0] PMWC_RAM_RET_RST = 8'hff;
   localparam logic [15:0] PMWC_CLK_GATE_RST = 16'hffff;
   // Wake source bit 7 is the combined pin wake; reset source bit 6 is wake event.
   localparam int PMWC_WAKE_PIN_BIT = 7;
   localparam int PMWC_RST_WAKE_BIT = 6;
   localparam logic [1:0] PMWC_RESP_OKAY = 2'b00;
   localparam logic [1:0] PMWC_RESP_SLVERR = 2'b10;

   typedef enum logic [4:0] {
      PMWC_ST_PWRUP = 5'b00001,
      PMWC_ST_RUN = 5'b00010,
      PMWC_ST_LIGHT = 5'b00100,
      PMWC_ST_STOP = 5'b01000,
      PMWC_ST_DEEP = 5'b10000
   } pmwc_state_t;
endpackage : pmwc_pkg

// [core/pmwc_top.sv]
`timescale 1ns/10ps
// What this block does
// - Core held from fetching until core supply reports valid.
// - Device reset held while battery is below reset threshold.
// - Low-battery warning flag raised below early warning threshold.
// - Software enables analog power system and each of three regulators.
// - Each regulator selects battery or buck output as source.
// - Drive supply pin selector picks battery or buck output.
// - Fourteen individually enabled pin wake inputs wake from deep sleep.
// - Eight deep-sleep wake sources, each individually enabled.
// - Configured reset sources exit deep sleep through reset.
// - Per-block retention selection for 4 kB RAM blocks in deep sleep.
// - Asleep indicator asserted while in deep sleep.
// - Wait without deep request halts core, peripheral clocks keep running.
// - Deep request on wait enters stop or deep per target select.
// - Stop halts all clocks; fast wake keeps a slow clock running.
// - Deep sleep disables regulators, powers core down, keeps retained state.
// - Low-power peripherals keep running in deep sleep.
// - Deep sleep held until a configured reset source or a battery reset occurs.
// - Each peripheral has its own software clock enable.
module pmwc_top
   import pmwc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog status inputs (asynchronous)
   input wire logic core_supply_ok,
   input wire logic bat_below_reset,
   input wire logic bat_below_warn,
   // Core side
   input wire logic core_wait,
   input wire logic deep_sleep_request,
   output logic core_run_en,
   output logic core_clk_en,
   output logic core_power_en,
   output logic device_reset,
   // Wake and reset sources (asynchronous levels)
   input wire logic [PMWC_NUM_PIN_WAKE-1:0] pin_wake,
   input wire logic [PMWC_NUM_WAKE-2:0] wake_src,
   input wire logic [PMWC_NUM_RST-2:0] rst_src,
   // Power and clock outputs
   output logic analog_en,
   output logic [2:0] regulator_group_en,
   output logic [2:0] regulator_group_src_buck,
   output logic drive_src_buck,
   output logic periph_clk_en,
   output logic [PMWC_NUM_PERIPH-1:0] peripheral_clock_gating,
   output logic slow_clk_keep,
   output logic slow_clk_sel_rtc,
   output logic lowpower_periph_en,
   output logic [PMWC_NUM_RAM-1:0] ram_retain,
   output logic [PMWC_NUM_RAM-1:0] ram_power_en,
   output logic low_batt_warn,
   output logic asleep
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SYNC_W = 3 + PMWC_NUM_PIN_WAKE + PMWC_NUM_WAKE - 1 + PMWC_NUM_RST - 1;
   logic [SYNC_W-1:0] sync_a_q;
   logic [SYNC_W-1:0] sync_b_q;
   logic supply_ok_s, bat_rst_s, bat_warn_s;
   logic [PMWC_NUM_PIN_WAKE-1:0] pin_wake_s;
   logic [PMWC_NUM_WAKE-2:0] wake_s;
   logic [PMWC_NUM_RST-2:0] rst_s;

   // Levels from other domains are read only after the second flop.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_a_q <= '0;
         sync_b_q <= '0;
      end else begin
         sync_a_q <= {core_supply_ok, bat_below_reset, bat_below_warn, pin_wake, wake_src,
                      rst_src};
         sync_b_q <= sync_a_q;
      end
   end
   assign {supply_ok_s, bat_rst_s, bat_warn_s, pin_wake_s, wake_s, rst_s} = sync_b_q;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [PMWC_NUM_WAKE-1:0] wake_en_q;
   logic [PMWC_NUM_PIN_WAKE-1:0] pin_wake_en_q;
   logic [PMWC_NUM_RST-1:0] rst_en_q;
   logic [PMWC_NUM_RAM-1:0] ram_ret_q;
   logic [PMWC_NUM_PERIPH-1:0] clk_gate_q;
   logic warn_flag_q;
   logic warn_clr;

   // Byte-lane merge used by every writable register.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic [31:0] m;

   assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign m = merge(32'h0000_0000, w_data_q, w_strb_q);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PMWC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[7:2] <= PMWC_STATUS_OFS[7:2] && aw_addr_q[1:0] == 2'b00) begin
               s_axi_bresp <= PMWC_RESP_OKAY;
            end else begin
               s_axi_bresp <= PMWC_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file; the warning flag is cleared by writing one to status bit 0.
   // Narrow registers keep only their own low bits of the merged word.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_q <= PMWC_CTRL_RST;
         wake_en_q <= PMWC_WAKE_EN_RST;
         pin_wake_en_q <= PMWC_PIN_WAKE_EN_RST;
         rst_en_q <= PMWC_RST_EN_RST;
         ram_ret_q <= PMWC_RAM_RET_RST;
         clk_gate_q <= PMWC_CLK_GATE_RST;
      end else if (wr_go) begin
         if (aw_addr_q == PMWC_CTRL_OFS) begin
            ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_3777;
         end else if (aw_addr_q == PMWC_WAKE_EN_OFS) begin
            wake_en_q <= 8'(merge({24'h0, wake_en_q}, w_data_q, w_strb_q));
         end else if (aw_addr_q == PMWC_PIN_WAKE_EN_OFS) begin
            pin_wake_en_q <= 14'(merge({18'h0, pin_wake_en_q}, w_data_q, w_strb_q));
         end else if (aw_addr_q == PMWC_RST_EN_OFS) begin
            rst_en_q <= 7'(merge({25'h0, rst_en_q}, w_data_q, w_strb_q));
         end else if (aw_addr_q == PMWC_RAM_RET_OFS) begin
            ram_ret_q <= 8'(merge({24'h0, ram_ret_q}, w_data_q, w_strb_q));
         end else if (aw_addr_q == PMWC_CLK_GATE_OFS) begin
            clk_gate_q <= 16'(merge({16'h0, clk_gate_q}, w_data_q, w_strb_q));
         end
      end
   end
   assign warn_clr = wr_go && aw_addr_q == PMWC_STATUS_OFS && m[0];

   // Sticky warning; a new low reading wins over a clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         warn_flag_q <= 1'b0;
      end else if (bat_warn_s) begin
         warn_flag_q <= 1'b1;
      end else if (warn_clr) begin
         warn_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Power mode state machine
   // ----------------------------------------------------------------
   pmwc_state_t state_q, state_d;
   logic wake_any, rst_any, deep_rst_q;
   logic [PMWC_NUM_WAKE-1:0] wake_vec;
   logic [PMWC_NUM_RST-1:0] rst_vec;

   assign wake_vec = {|(pin_wake_s & pin_wake_en_q), wake_s};
   assign wake_any = |(wake_vec & wake_en_q);
   assign rst_vec = {wake_any, rst_s};
   assign rst_any = |(rst_vec & rst_en_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         PMWC_ST_PWRUP: begin
            if (supply_ok_s && !bat_rst_s) begin
               state_d = PMWC_ST_RUN;
            end
         end
         PMWC_ST_RUN: begin
            if (core_wait && !deep_sleep_request) begin
               state_d = PMWC_ST_LIGHT;
            end else if (core_wait && !ctrl_q[PMWC_CTRL_SLEEP_TARGET]) begin
               state_d = PMWC_ST_STOP;
            end else if (core_wait) begin
               state_d = PMWC_ST_DEEP;
            end
         end
         PMWC_ST_LIGHT: begin
            if (!core_wait) begin
               state_d = PMWC_ST_RUN;
            end
         end
         PMWC_ST_STOP: begin
            // Wake does not wait for the core to drop its wait line.
            if (wake_any || rst_any) begin
               state_d = PMWC_ST_RUN;
            end
         end
         PMWC_ST_DEEP: begin
            // Only a configured reset source, through deep_rst_q, or a battery reset ends deep sleep.
            state_d = PMWC_ST_DEEP;
         end
         default: begin
            state_d = PMWC_ST_PWRUP;
         end
      endcase
      if (bat_rst_s || deep_rst_q) begin
         state_d = PMWC_ST_PWRUP;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= PMWC_ST_PWRUP;
      end else begin
         state_q <= state_d;
      end
   end

   // A configured reset source in deep sleep pulses device reset for one cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         deep_rst_q <= 1'b0;
      end else begin
         deep_rst_q <= state_q == PMWC_ST_DEEP && rst_any && !deep_rst_q;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   // State-dependent outputs follow state_d so they switch on the same edge as the state.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         core_run_en <= 1'b0;
         core_clk_en <= 1'b0;
         core_power_en <= 1'b0;
         device_reset <= 1'b1;
         periph_clk_en <= 1'b0;
         asleep <= 1'b0;
         analog_en <= 1'b0;
         regulator_group_en <= 3'b000;
         regulator_group_src_buck <= 3'b000;
         drive_src_buck <= 1'b0;
         peripheral_clock_gating <= '0;
         slow_clk_keep <= 1'b0;
         slow_clk_sel_rtc <= 1'b0;
         lowpower_periph_en <= 1'b0;
         ram_retain <= '0;
         ram_power_en <= '0;
         low_batt_warn <= 1'b0;
      end else begin
         core_run_en <= state_d == PMWC_ST_RUN;
         core_clk_en <= state_d == PMWC_ST_RUN;
         core_power_en <= state_d != PMWC_ST_DEEP;
         device_reset <= bat_rst_s || deep_rst_q || state_d == PMWC_ST_PWRUP;
         periph_clk_en <= state_d == PMWC_ST_RUN || state_d == PMWC_ST_LIGHT;
         asleep <= state_d == PMWC_ST_DEEP;
         analog_en <= ctrl_q[PMWC_CTRL_ANALOG_EN];
         regulator_group_en <= (state_d == PMWC_ST_DEEP) ? 3'b000 :
                               ctrl_q[PMWC_CTRL_REG_EN +: 3];
         regulator_group_src_buck <= ctrl_q[PMWC_CTRL_REG_SRC +: 3];
         drive_src_buck <= ctrl_q[PMWC_CTRL_DRV_SRC];
         peripheral_clock_gating <= clk_gate_q;
         slow_clk_keep <= state_d != PMWC_ST_STOP || ctrl_q[PMWC_CTRL_FAST_WAKE];
         slow_clk_sel_rtc <= ctrl_q[PMWC_CTRL_FAST_SRC];
         lowpower_periph_en <= state_d != PMWC_ST_PWRUP;
         ram_retain <= ram_ret_q;
         ram_power_en <= (state_d == PMWC_ST_DEEP) ? ram_ret_q : '1;
         low_batt_warn <= warn_flag_q;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PMWC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= PMWC_RESP_OKAY;
            if (s_axi_araddr == PMWC_CTRL_OFS) begin
               s_axi_rdata <= ctrl_q;
            end else if (s_axi_araddr == PMWC_WAKE_EN_OFS) begin
               s_axi_rdata <= {24'h0, wake_en_q};
            end else if (s_axi_araddr == PMWC_PIN_WAKE_EN_OFS) begin
               s_axi_rdata <= {18'h0, pin_wake_en_q};
            end else if (s_axi_araddr == PMWC_RST_EN_OFS) begin
               s_axi_rdata <= {25'h0, rst_en_q};
            end else if (s_axi_araddr == PMWC_RAM_RET_OFS) begin
               s_axi_rdata <= {24'h0, ram_ret_q};
            end else if (s_axi_araddr == PMWC_CLK_GATE_OFS) begin
               s_axi_rdata <= {16'h0, clk_gate_q};
            end else if (s_axi_araddr == PMWC_STATUS_OFS) begin
               s_axi_rdata <= {19'h0, state_q, 5'h0, supply_ok_s, bat_rst_s, warn_flag_q};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= PMWC_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : pmwc_top

// [tb/pmwc_chk.sv]
`timescale 1ns/10ps
module pmwc_chk
   import pmwc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Supply and core link
   input wire logic core_supply_ok,
   input wire logic bat_below_reset,
   input wire logic bat_below_warn,
   input wire logic core_wait,
   input wire logic deep_sleep_request,
   input wire logic core_run_en,
   input wire logic core_clk_en,
   input wire logic core_power_en,
   input wire logic device_reset,
   // Wake sources and power outputs
   input wire logic [PMWC_NUM_PIN_WAKE-1:0] pin_wake,
   input wire logic [PMWC_NUM_WAKE-2:0] wake_src,
   input wire logic [PMWC_NUM_RST-2:0] rst_src,
   input wire logic periph_clk_en,
   input wire logic lowpower_periph_en,
   input wire logic [PMWC_NUM_RAM-1:0] ram_retain,
   input wire logic [PMWC_NUM_RAM-1:0] ram_power_en,
   input wire logic low_batt_warn,
   input wire logic asleep
);
   // ----------------------------------------------------------------
   // Source history and properties
   // ----------------------------------------------------------------
   // Six cycles of history cover the synchroniser and the state latency.
   logic [5:0] src_hist_q;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         src_hist_q <= 6'h00;
      end else begin
         src_hist_q <= {src_hist_q[4:0], (|pin_wake) | (|wake_src) | (|rst_src)};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence quiet;
      pin_wake == '0 && wake_src == '0 && rst_src == '0 && !bat_below_reset;
   endsequence
   sequence stop_st;
      !periph_clk_en && !core_run_en && core_power_en && !device_reset && lowpower_periph_en;
   endsequence
   a_fetch_gated: assert property (
      $rose(core_run_en) |-> $past(core_supply_ok, 2) && !device_reset)
      else $error("core started without valid supply");
   a_batt_reset: assert property (
      bat_below_reset [*5] |-> device_reset && !core_run_en)
      else $error("low battery did not hold reset");
   a_warn_flag: assert property (
      bat_below_warn [*5] |-> low_batt_warn)
      else $error("low battery warning missing");
   a_light_sleep: assert property (
      core_run_en && core_wait && !deep_sleep_request |-> ##[1:3] (!core_clk_en && periph_clk_en))
      else $error("light sleep not entered");
   a_deep_halt: assert property (
      core_run_en && core_wait && deep_sleep_request |-> ##[1:3] (!core_clk_en && !periph_clk_en))
      else $error("deep request did not halt clocks");
   a_stop_exit: assert property (
      stop_st ##1 core_run_en |-> src_hist_q != 6'h00)
      else $error("stop left without a source");
   a_deep_hold: assert property (
      quiet [*5] ##0 asleep |=> asleep)
      else $error("deep sleep left without a source");
   a_deep_power: assert property (
      asleep |-> !core_power_en && !core_clk_en && lowpower_periph_en && ram_power_en == ram_retain)
      else $error("deep sleep power state wrong");
   a_ram_awake: assert property (
      !asleep && !$past(srst) |-> ram_power_en == '1)
      else $error("ram powered down while awake");
endmodule : pmwc_chk

bind pmwc_top pmwc_chk u_chk (.*);

// [tb/pmwc_core_model.sv]
`timescale 1ns/10ps
module pmwc_core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Bench commands
   input wire logic sleep_cmd,
   input wire logic deep_cmd,
   // Power controller link
   input wire logic core_run_en,
   output logic core_wait = 1'b0,
   output logic deep_sleep_request = 1'b0
);
   // ----------------------------------------------------------------
   // Wait instruction sequencing
   // ----------------------------------------------------------------
   logic [1:0] bar_q = 2'h0;
   logic slept_q = 1'b0;
   always @(posedge ref_clk) begin
      if (srst) begin
         core_wait <= 1'b0;
         deep_sleep_request <= 1'b0;
         bar_q <= 2'h0;
         slept_q <= 1'b0;
      end else if (!core_wait) begin
         deep_sleep_request <= deep_cmd;
         // Two barrier cycles let bus traffic drain before the wait is issued.
         bar_q <= (sleep_cmd && core_run_en) ? bar_q + 2'h1 : 2'h0;
         if (bar_q == 2'h2) begin
            core_wait <= 1'b1;
            bar_q <= 2'h0;
         end
         slept_q <= 1'b0;
      end else begin
         slept_q <= slept_q | !core_run_en;
         // A core halted on a deep request drops the wait line, so a woken core cannot re-enter sleep at once.
         if (!sleep_cmd || (slept_q && deep_sleep_request)) begin
            core_wait <= 1'b0;
         end
      end
   end
endmodule : pmwc_core_model

// [tb/pmwc_tb_top.sv]
`timescale 1ns/10ps
module pmwc_tb_top;
   import pmwc_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_cmd = 1'b0, deep_cmd = 1'b0;
   logic core_supply_ok = 1'b0, bat_below_reset = 1'b0, bat_below_warn = 1'b0;
   logic [13:0] pin_wake = 14'h0000;
   logic [6:0] wake_src = 7'h00;
   logic [5:0] rst_src = 6'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic core_wait, deep_sleep_request, core_run_en, core_clk_en, core_power_en;
   logic device_reset, analog_en, drive_src_buck, periph_clk_en, slow_clk_keep;
   logic slow_clk_sel_rtc, lowpower_periph_en, low_batt_warn, asleep;
   logic [2:0] regulator_group_en, regulator_group_src_buck;
   logic [15:0] peripheral_clock_gating;
   logic [7:0] ram_retain, ram_power_en;
   logic [7:0] ofs_tbl [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   logic [31:0] rst_tbl [6] = '{32'h0000_2070, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0001, 32'h0000_00ff, 32'h0000_ffff};
   int num_errors = 0;
   int total_checks = 0;
   always #25 ref_clk = ~ref_clk;
   pmwc_top DUT (.*);
   pmwc_core_model u_core (.ref_clk, .srst, .sleep_cmd, .deep_cmd, .core_run_en,
      .core_wait, .deep_sleep_request);
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t value %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic pick(input int sel);
      case (sel)
         0: return core_run_en;
         1: return periph_clk_en;
         2: return asleep;
         default: return device_reset;
      endcase
   endfunction : pick
   // Waits are bounded so that a stuck state shows as one mismatch, not a hang.
   task automatic wait_for(input int sel, input logic val);
      int n;
      n = 0;
      while (pick(sel) !== val && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      check({31'h0, n < 400}, 32'h0000_0001);
   endtask : wait_for
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, r});
      @(posedge ref_clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, e);
      check({30'h0, s_axi_rresp}, {30'h0, r});
   endtask : axi_rd
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      check({core_run_en, device_reset}, 2'b01);
      core_supply_ok <= 1'b1;
      wait_for(0, 1'b1);
      check(device_reset, 1'b0);
      $display("test power_up done");
      for (int i = 0; i < 6; i++) begin
         axi_rd(ofs_tbl[i], rst_tbl[i], PMWC_RESP_OKAY);
      end
      axi_rd(8'h18, 32'h0000_0204, PMWC_RESP_OKAY);
      axi_rd(8'h1c, 32'h0000_0000, PMWC_RESP_SLVERR);
      axi_wr(8'h1c, 32'h0000_ffff, PMWC_RESP_SLVERR);
      axi_wr(8'h00, 32'h0000_3554, PMWC_RESP_OKAY);
      check({regulator_group_en, regulator_group_src_buck}, 6'b101_101);
      check({analog_en, drive_src_buck, slow_clk_sel_rtc}, 3'b111);
      axi_wr(8'h00, 32'h0000_0260, PMWC_RESP_OKAY);
      check({regulator_group_en, regulator_group_src_buck}, 6'b110_010);
      check({analog_en, drive_src_buck, slow_clk_sel_rtc}, 3'b000);
      axi_wr(8'h14, 32'h0000_a5c3, PMWC_RESP_OKAY);
      check(peripheral_clock_gating, 16'ha5c3);
      axi_wr(8'h10, 32'h0000_0005, PMWC_RESP_OKAY);
      check(ram_retain, 8'h05);
      $display("test registers done");
      sleep_cmd <= 1'b1;
      wait_for(0, 1'b0);
      check({core_clk_en, periph_clk_en}, 2'b01);
      axi_rd(8'h18, 32'h0000_0404, PMWC_RESP_OKAY);
      sleep_cmd <= 1'b0;
      wait_for(0, 1'b1);
      $display("test light_sleep done");
      axi_wr(8'h04, 32'h0000_0001, PMWC_RESP_OKAY);
      axi_wr(8'h00, 32'h0000_2072, PMWC_RESP_OKAY);
      sleep_cmd <= 1'b1;
      deep_cmd <= 1'b1;
      wait_for(1, 1'b0);
      sleep_cmd <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check({core_clk_en, asleep, slow_clk_keep}, 3'b001);
      axi_rd(8'h18, 32'h0000_0804, PMWC_RESP_OKAY);
      wake_src <= 7'h02;
      repeat (8) @(posedge ref_clk);
      check(periph_clk_en, 1'b0);
      wake_src <= 7'h01;
      wait_for(0, 1'b1);
      check({periph_clk_en, device_reset}, 2'b10);
      wake_src <= 7'h00;
      $display("test stop done");
      axi_wr(8'h08, 32'h0000_0008, PMWC_RESP_OKAY);
      axi_wr(8'h04, 32'h0000_0080, PMWC_RESP_OKAY);
      axi_wr(8'h0c, 32'h0000_0040, PMWC_RESP_OKAY);
      axi_wr(8'h00, 32'h0000_2071, PMWC_RESP_OKAY);
      sleep_cmd <= 1'b1;
      wait_for(2, 1'b1);
      sleep_cmd <= 1'b0;
      deep_cmd <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check({core_power_en, core_clk_en, lowpower_periph_en}, 3'b001);
      check(ram_power_en, 8'h05);
      pin_wake <= 14'h0004;
      rst_src <= 6'h01;
      repeat (10) @(posedge ref_clk);
      check(asleep, 1'b1);
      pin_wake <= 14'h0008;
      wait_for(3, 1'b1);
      pin_wake <= 14'h0000;
      rst_src <= 6'h00;
      wait_for(0, 1'b1);
      axi_rd(8'h00, 32'h0000_2071, PMWC_RESP_OKAY);
      $display("test deep_sleep done");
      bat_below_warn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check(low_batt_warn, 1'b1);
      axi_rd(8'h18, 32'h0000_0205, PMWC_RESP_OKAY);
      bat_below_warn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check(low_batt_warn, 1'b1);
      axi_wr(8'h18, 32'h0000_0001, PMWC_RESP_OKAY);
      check(low_batt_warn, 1'b0);
      bat_below_reset <= 1'b1;
      repeat (12) @(posedge ref_clk);
      check({device_reset, core_run_en}, 2'b10);
      bat_below_reset <= 1'b0;
      wait_for(0, 1'b1);
      $display("test battery done");
      conclude();
   end
endmodule : pmwc_tb_top
